// *** src/shade_pkg.sv ***
package shade_pkg;
  // Register byte addresses
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] BRIGHT_OFS  = 12'h004;
  localparam logic [11:0] EXT_LUX_OFS = 12'h008;
  localparam logic [11:0] LON_OFS     = 12'h00c;
  localparam logic [11:0] LAT_OFS     = 12'h010;
  localparam logic [11:0] HGT_OFS     = 12'h014;
  localparam logic [11:0] STATUS_OFS  = 12'h018;
  localparam logic [11:0] FAC_BASE    = 12'h040;
  // Word index inside one 16-byte facade block
  localparam logic [1:0]  FAC_CFG     = 2'h0;
  localparam logic [1:0]  FAC_ANG     = 2'h1;
  localparam logic [1:0]  FAC_STG     = 2'h2;
  localparam logic [1:0]  FAC_PCT     = 2'h3;
  // Field positions
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_GPS_BIT = 1;
  localparam int          CTRL_EXT_BIT = 2;
  localparam int          HYST_LSB     = 8;
  localparam int          ST_DIS_LSB   = 8;
  localparam int          ST_BRIGHT    = 16;
  localparam int          ST_TIME      = 17;
  // Scaling, limits and reset values
  localparam logic [19:0] LUX_PER_KLUX = 20'h003e8;
  localparam logic [7:0]  POS_FULL     = 8'h64;
  localparam logic signed [31:0] LON_MAX = 32'sh0000_00b4;
  localparam logic signed [31:0] LAT_MAX = 32'sh0000_005a;
  localparam logic [15:0] HGT_MAX      = 16'h2290;
  localparam logic [15:0] HGT_RST      = 16'h00fa;
  localparam logic [5:0]  KLUX_RST     = 6'h0a;
  localparam logic [4:0]  HYST_RST     = 5'h03;
  localparam logic [8:0]  HALF_TURN    = 9'h0b4;
  localparam logic [8:0]  FULL_TURN    = 9'h168;
  localparam logic [7:0]  OPEN_RST     = 8'h96;

  typedef struct packed {
    logic       shade;
    logic [2:0] stage;
    logic [7:0] pos;
  } height_obj_type;

  typedef struct packed {
    logic signed [31:0] lon;
    logic signed [31:0] lat;
    logic        [15:0] hgt;
  } site_type;

  typedef struct packed {
    logic       end_track;
    logic       begin_zero;
    logic       dis_en;
    logic       dis_pol;
    logic [2:0] stage_en;
    logic       byte_mode;
  } facade_cfg_type;

  typedef struct packed {
    logic [7:0] open;
    logic [8:0] orient;
  } facade_ang_type;

  typedef struct packed {
    logic signed [7:0] elevation_stage_third;
    logic signed [7:0] elevation_stage_second;
    logic signed [7:0] elevation_stage_first;
  } facade_stg_type;
endpackage : shade_pkg

// *** src/facade_shading_height_control.sv ***
// How it works
// RULE_01: Facade staging runs only while brightness is high and azimuth is in opening.
// RULE_02: Three elevation thresholds per facade, each enabled on its own.
// RULE_03: Bit mode: elevation above an enabled threshold sets that threshold's bit.
// RULE_04: Byte mode: above an enabled threshold, send that threshold's percentage.
// RULE_05: Software sets higher thresholds larger than lower ones.
// RULE_06: Byte mode, active, below first threshold: position is 100 percent.
// RULE_07: Shading end drives all bits to 0 and position to 0 percent.
// RULE_08: Bands map to 100, first, second, third percent; bits set cumulatively.
// RULE_09: Per-facade disable input with configurable polarity.
// RULE_10: Separate behaviours on entering and leaving the disabled state.
// RULE_11: A disabled facade sends nothing.
// RULE_12: After disable ends, sending resumes at next cyclic send or change.
// RULE_13: Tracking end behaviour updates the objects at once.
// RULE_14: Every facade starts enabled after reset.
// RULE_15: Without valid time, all objects go to 0, disabled facades too.
// RULE_16: Nothing runs unless the global shading enable is set.
// RULE_17: With satellite positioning off, configured site coordinates are used.
// RULE_18: Longitude held as four bytes, -180 to +180, east positive.
// RULE_19: Latitude held from -90 to +90, north positive.
// RULE_20: Height held as two bytes, 0 to 8848 metres.
// RULE_21: Basic brightness threshold is internal or an external bus value.
// RULE_22: Internal threshold is the kilolux setting times one thousand.
// RULE_23: Shading drops only below threshold minus hysteresis times one thousand.
// RULE_24: Objects are sent only on value change or cyclic send.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module facade_shading_height_control
  import shade_pkg::*;
#(
  parameter int NUM_FACADES = 8,
  parameter int LUX_W       = 20
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Sensor and sun values
  input  wire logic [3:0][LUX_W-1:0]      bright_lux,
  input  wire logic [8:0]                 sun_azimuth,
  input  wire logic signed [7:0]          sun_elevation,
  input  wire logic                       time_valid,
  // Satellite site data
  input  wire logic                       gps_fix,
  input  wire site_type                   gps_site,
  // Per-facade bus objects
  input  wire logic [NUM_FACADES-1:0]     disable_wr,
  input  wire logic [NUM_FACADES-1:0]     disable_val,
  input  wire logic [NUM_FACADES-1:0]     cyclic_due,
  // Outputs toward actuators, and the site in use
  output height_obj_type [NUM_FACADES-1:0] height_obj,
  output logic      [NUM_FACADES-1:0]     height_send,
  output site_type                        site
);

  logic                             ctrl_en, ctrl_gps, ctrl_ext;
  logic [5:0]                       klux;
  logic [4:0]                       hyst;
  logic [LUX_W-1:0]                 ext_lux;
  site_type                         cfg_site;
  facade_cfg_type [NUM_FACADES-1:0] fcfg;
  facade_ang_type [NUM_FACADES-1:0] fang;
  facade_stg_type [NUM_FACADES-1:0] fstg;
  logic [NUM_FACADES-1:0][23:0]     fpct;
  logic                             next_ctrl_en, next_ctrl_gps, next_ctrl_ext;
  logic [5:0]                       next_klux;
  logic [4:0]                       next_hyst;
  logic [LUX_W-1:0]                 next_ext_lux;
  site_type                         next_cfg_site;
  facade_cfg_type [NUM_FACADES-1:0] next_fcfg;
  facade_ang_type [NUM_FACADES-1:0] next_fang;
  facade_stg_type [NUM_FACADES-1:0] next_fstg;
  logic [NUM_FACADES-1:0][23:0]     next_fpct;
  logic [31:0]                      next_prdata;
  logic [NUM_FACADES-1:0]           active, dis;
  logic                             bright_on, next_bright_on;
  logic                             hit, fac_hit;
  logic [3:0]                       fsel;

  // Address decode; facade blocks follow the global words
  always_comb begin
    fsel    = 4'(paddr[7:4] - FAC_BASE[7:4]);
    fac_hit = (paddr[11:8] == 4'h0) && (paddr[7:4] >= FAC_BASE[7:4])
              && (int'(fsel) < NUM_FACADES) && (paddr[1:0] == 2'b00);
    hit     = fac_hit || (paddr inside {CTRL_OFS, BRIGHT_OFS, EXT_LUX_OFS,
                                        LON_OFS, LAT_OFS, HGT_OFS, STATUS_OFS});
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Register writes, taken in the access phase
  always_comb begin
    next_ctrl_en  = ctrl_en;
    next_ctrl_gps = ctrl_gps;
    next_ctrl_ext = ctrl_ext;
    next_klux     = klux;
    next_hyst     = hyst;
    next_ext_lux  = ext_lux;
    next_cfg_site = cfg_site;
    next_fcfg     = fcfg;
    next_fang     = fang;
    next_fstg     = fstg;
    next_fpct     = fpct;
    if (psel && penable && pwrite && hit) begin
      if (fac_hit) begin
        unique case (paddr[3:2])
          FAC_CFG: next_fcfg[fsel[2:0]] = pwdata[7:0];
          FAC_ANG: next_fang[fsel[2:0]] = {pwdata[23:16], pwdata[8:0]};
          FAC_STG: next_fstg[fsel[2:0]] = pwdata[23:0]; // RULE_05
          FAC_PCT: next_fpct[fsel[2:0]] = pwdata[23:0];
        endcase
      end else begin
        unique case (paddr)
          CTRL_OFS: begin
            next_ctrl_en  = pwdata[CTRL_EN_BIT];
            next_ctrl_gps = pwdata[CTRL_GPS_BIT];
            next_ctrl_ext = pwdata[CTRL_EXT_BIT];
          end
          BRIGHT_OFS: begin
            next_klux = pwdata[5:0];
            next_hyst = pwdata[HYST_LSB+:5];
          end
          EXT_LUX_OFS: next_ext_lux = pwdata[LUX_W-1:0]; // RULE_21
          // Out-of-range coordinates are dropped, old value kept
          LON_OFS: if ($signed(pwdata) <= LON_MAX && $signed(pwdata) >= -LON_MAX)
            next_cfg_site.lon = pwdata; // RULE_18
          LAT_OFS: if ($signed(pwdata) <= LAT_MAX && $signed(pwdata) >= -LAT_MAX)
            next_cfg_site.lat = pwdata; // RULE_19
          HGT_OFS: if (pwdata[31:16] == 16'h0000 && pwdata[15:0] <= HGT_MAX)
            next_cfg_site.hgt = pwdata[15:0]; // RULE_20
          default: ;
        endcase
      end
    end
  end

  // Read data latched in the setup phase, so it stands through access
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (fac_hit) begin
        unique case (paddr[3:2])
          FAC_CFG: next_prdata = {24'h000000, fcfg[fsel[2:0]]};
          FAC_ANG: next_prdata = {8'h00, fang[fsel[2:0]].open, 7'h00,
                                  fang[fsel[2:0]].orient};
          FAC_STG: next_prdata = {8'h00, fstg[fsel[2:0]]};
          FAC_PCT: next_prdata = {8'h00, fpct[fsel[2:0]]};
        endcase
      end else begin
        unique case (paddr)
          CTRL_OFS:    next_prdata = {29'h0, ctrl_ext, ctrl_gps, ctrl_en};
          BRIGHT_OFS:  next_prdata = {19'h0, hyst, 2'h0, klux};
          EXT_LUX_OFS: next_prdata = 32'(ext_lux);
          LON_OFS:     next_prdata = cfg_site.lon;
          LAT_OFS:     next_prdata = cfg_site.lat;
          HGT_OFS:     next_prdata = {16'h0000, cfg_site.hgt};
          STATUS_OFS: begin
            next_prdata[NUM_FACADES-1:0]          = active;
            next_prdata[ST_DIS_LSB+:NUM_FACADES]  = dis;
            next_prdata[ST_BRIGHT]                = bright_on;
            next_prdata[ST_TIME]                  = time_valid;
          end
          default: ;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en      <= 1'b0;
      ctrl_gps     <= 1'b0;
      ctrl_ext     <= 1'b0;
      klux         <= KLUX_RST;
      hyst         <= HYST_RST;
      ext_lux      <= '0;
      cfg_site     <= '{lon: 32'sh0, lat: 32'sh0, hgt: HGT_RST};
      fcfg         <= '0;
      fang         <= '0;
      fstg         <= '0;
      fpct         <= '0;
      prdata       <= 32'h0000_0000;
    end else begin
      ctrl_en      <= next_ctrl_en;
      ctrl_gps     <= next_ctrl_gps;
      ctrl_ext     <= next_ctrl_ext;
      klux         <= next_klux;
      hyst         <= next_hyst;
      ext_lux      <= next_ext_lux;
      cfg_site     <= next_cfg_site;
      fcfg         <= next_fcfg;
      fang         <= next_fang;
      fstg         <= next_fstg;
      fpct         <= next_fpct;
      prdata       <= next_prdata;
    end
  end

  // Manual site is used unless satellite positioning is on and a live fix exists
  assign site = (ctrl_gps && gps_fix) ? gps_site : cfg_site; // RULE_17

  // Basic brightness with hysteresis; any of the four sensors may start it
  logic [LUX_W-1:0] thr_lux, hyst_lux, off_lux;
  logic             any_above, all_below;
  always_comb begin
    thr_lux  = ctrl_ext ? ext_lux
                        : LUX_W'(LUX_PER_KLUX * {14'h0, klux}); // RULE_21 RULE_22
    hyst_lux = LUX_W'(LUX_PER_KLUX * {15'h0, hyst}); // RULE_23
    off_lux  = (thr_lux > hyst_lux) ? LUX_W'(thr_lux - hyst_lux) : '0;
    any_above = 1'b0;
    all_below = 1'b1;
    for (int s = 0; s < 4; s++) begin
      if (bright_lux[s] > thr_lux) any_above = 1'b1;
      if (bright_lux[s] >= off_lux) all_below = 1'b0;
    end
    next_bright_on = bright_on;
    if (!ctrl_en) next_bright_on = 1'b0; // RULE_16
    else if (any_above) next_bright_on = 1'b1;
    else if (all_below) next_bright_on = 1'b0; // RULE_23
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bright_on <= 1'b0;
    else bright_on <= next_bright_on;
  end

  // One staging and send path per facade
  for (genvar f = 0; f < NUM_FACADES; f++) begin : g_fac
    logic [8:0]     adiff, afold;
    logic           in_open, next_dis, next_send, dis_rise, dis_fall;
    logic           stale, next_stale; // Held object lags the live value
    logic [2:0]     above;
    height_obj_type want, next_obj, want_q;

    // Sun inside the opening angle, folded around the facade normal
    always_comb begin
      adiff   = (sun_azimuth >= fang[f].orient) ? 9'(sun_azimuth - fang[f].orient)
                                                : 9'(fang[f].orient - sun_azimuth);
      afold   = (adiff > HALF_TURN) ? 9'(FULL_TURN - adiff) : adiff;
      in_open = (fang[f].open != 8'h00) && ({afold, 1'b0} <= {2'b00, fang[f].open});
      active[f] = ctrl_en && time_valid && bright_on && in_open; // RULE_01
    end

    // Stage bits follow each enabled threshold, cumulative when thresholds rise; byte value is the highest stage reached
    always_comb begin
      above[0] = fcfg[f].stage_en[0] && (sun_elevation > fstg[f].elevation_stage_first);
      above[1] = fcfg[f].stage_en[1] && (sun_elevation > fstg[f].elevation_stage_second);
      above[2] = fcfg[f].stage_en[2] && (sun_elevation > fstg[f].elevation_stage_third);
      want = '0; // RULE_07
      if (active[f]) begin
        want.shade = 1'b1;
        if (fcfg[f].byte_mode) begin
          want.pos = POS_FULL; // RULE_06
          for (int k = 0; k < 3; k++)
            if (above[k]) want.pos = fpct[f][8*k+:8]; // RULE_04 RULE_08
        end else begin
          want.stage = above; // RULE_02 RULE_03 RULE_08
        end
      end
    end

    // Disable moves on a written telegram and clears while dis_en is off; reset leaves it clear
    always_comb begin
      next_dis = dis[f];
      if (!fcfg[f].dis_en) next_dis = 1'b0;
      else if (disable_wr[f]) next_dis = (disable_val[f] == fcfg[f].dis_pol); // RULE_09
      dis_rise = next_dis && !dis[f];
      dis_fall = !next_dis && dis[f];
    end

    // Send decision; lost time wins over everything but global enable off, disable included
    always_comb begin
      next_send  = 1'b0;
      next_obj   = height_obj[f];
      next_stale = stale;
      if (!ctrl_en) begin
        next_obj   = '0; // RULE_16
        next_stale = 1'b0;
      end else if (!time_valid) begin
        next_obj   = '0;
        next_send  = (height_obj[f] != '0); // RULE_15
        next_stale = 1'b0;
      end else if (dis_rise) begin
        // Zeros go out once, and only if the actuator is not at zero already
        if (fcfg[f].begin_zero) begin
          next_obj  = '0; // RULE_10
          next_send = (height_obj[f] != '0);
        end
      end else if (dis_fall) begin
        // Untracked end leaves the held object stale until the next event
        next_send  = fcfg[f].end_track || cyclic_due[f]; // RULE_10 RULE_13
        next_stale = !next_send;
        if (next_send) next_obj = want;
      end else if (!dis[f] && stale) begin
        // A fresh change, a cyclic tick or shading end brings it back in step
        next_send  = (want != want_q && want != height_obj[f]) || cyclic_due[f]
                     || (!active[f] && height_obj[f] != '0); // RULE_07 RULE_12
        next_stale = !next_send && (want != height_obj[f]);
        if (next_send) next_obj = want;
      end else if (!dis[f]) begin
        next_send = (want != height_obj[f]) || cyclic_due[f]; // RULE_24
        if (next_send) next_obj = want;
      end
      // else disabled: hold and stay silent  RULE_11
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dis[f]         <= 1'b0; // RULE_14
        height_obj[f]  <= '0;
        height_send[f] <= 1'b0;
        stale          <= 1'b0;
        want_q         <= '0;
      end else begin
        dis[f]         <= next_dis;
        height_obj[f]  <= next_obj;
        height_send[f] <= next_send;
        stale          <= next_stale;
        want_q         <= want;
      end
    end

    // Disabled and time valid: no send, object frozen
    AST_DIS_SILENT: assert property (@(posedge pclk) disable iff (!presetn)
      dis[f] && $past(dis[f]) && $past(time_valid) && $past(ctrl_en)
      |-> !height_send[f] && $stable(height_obj[f]))
      else $error("disabled facade sent"); // RULE_11
    // Without tracking, the end of disabling alone sends nothing
    AST_END_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_en && time_valid && dis_fall && !fcfg[f].end_track && !cyclic_due[f]
      |=> !height_send[f])
      else $error("untracked disable end sent"); // RULE_12
    // Lost time drives the object to zero on the next edge
    AST_TIME_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_en && !time_valid |=> height_obj[f] == '0)
      else $error("object not cleared without time"); // RULE_15
    // Byte mode below first stage sends full height
    AST_BELOW_FULL: assert property (@(posedge pclk) disable iff (!presetn)
      active[f] && fcfg[f].byte_mode && above == 3'b000 && !dis[f] && !dis_rise
      |=> height_obj[f].pos == POS_FULL)
      else $error("position not full below first stage"); // RULE_06
    // Inactive facade, enabled, ends at all zero
    AST_END_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      !active[f] && !dis[f] && !next_dis ##1 !active[f] && !dis[f] |-> height_obj[f] == '0)
      else $error("objects not zero after shading end"); // RULE_07
    // Tracking end sends immediately
    AST_TRACK: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_en && time_valid && dis_fall && fcfg[f].end_track |=> height_send[f])
      else $error("tracking end did not send"); // RULE_13
    // A send without a cyclic tick, other than at a disable end, carries a changed value
    AST_NO_REPEAT: assert property (@(posedge pclk) disable iff (!presetn)
      height_send[f] && !$past(cyclic_due[f]) && !$past(dis[f]) && $past(time_valid)
      |-> height_obj[f] != $past(height_obj[f]))
      else $error("identical object resent"); // RULE_24
    // Bit mode, all stages enabled: third stage bit never set without the second
    AST_CUMUL: assert property (@(posedge pclk) disable iff (!presetn)
      fcfg[f].stage_en == 3'b111 && !fcfg[f].byte_mode
      |-> !(height_obj[f].stage[2] && !height_obj[f].stage[1])
          || $past(fcfg[f].stage_en) != 3'b111)
      else $error("stage bits not cumulative"); // RULE_08
  end

  // Configured site coordinates never leave their ranges
  AST_SITE_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_site.lon <= LON_MAX && cfg_site.lon >= -LON_MAX && cfg_site.hgt <= HGT_MAX
    && cfg_site.lat <= LAT_MAX && cfg_site.lat >= -LAT_MAX)
    else $error("site value out of range"); // RULE_18
  // Brightness above threshold switches shading on next edge
  AST_BRIGHT_ON: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_en && any_above |=> bright_on)
    else $error("brightness did not start shading"); // RULE_01
  // Global enable off keeps every facade silent and brightness off
  AST_GLOBAL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_en |=> height_send == '0 && !bright_on)
    else $error("disabled function acted"); // RULE_16

endmodule : facade_shading_height_control
`default_nettype wire

// *** test/actuator_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module actuator_model
  import shade_pkg::*;
#(
  parameter int N = 8
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Telegrams from the facades
  input  wire height_obj_type [N-1:0] height_obj,
  input  wire logic [N-1:0]           height_send,
  // What each actuator last received, and the count of telegrams sent
  output var height_obj_type [N-1:0]  last,
  output var logic [15:0]             n_sent
);
  // Actuators see only sent telegrams, never the idle object value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last   <= '0;
      n_sent <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (height_send[i]) begin
          last[i] <= height_obj[i];
        end
      end
      n_sent <= n_sent + 16'($countones(height_send));
    end
  end
endmodule : actuator_model
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
  import shade_pkg::*;
;
  localparam int NF = 2;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, time_valid = 1'b0, gps_fix = 1'b0;
  logic [3:0][19:0] bright_lux = '0;
  logic [8:0] sun_azimuth = 9'h0b4;
  logic signed [7:0] sun_elevation = 8'sh05;
  site_type gps_site = '0, site;
  logic [NF-1:0] disable_wr = '0, disable_val = '0, cyclic_due = '0, height_send;
  height_obj_type [NF-1:0] height_obj, last;
  logic [15:0] n_sent, sent0;
  logic [11:0] x;
  int n_mismatch = 0, checks = 0, cyc = 0, seed = 32'h02f3;
  logic [11:0] ra [6] = '{HGT_OFS, HGT_OFS, LON_OFS, LON_OFS, LAT_OFS, LAT_OFS};
  logic [31:0] rv [6] = '{32'h2291, 32'h2290, 32'hb5, 32'hffffff4c, 32'h5b, 32'hffffffa6};
  logic [31:0] re [6] = '{32'hfa, 32'h2290, 32'h0, 32'hffffff4c, 32'h0, 32'hffffffa6};

  facade_shading_height_control #(.NUM_FACADES(NF), .LUX_W(20)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bright_lux(bright_lux), .sun_azimuth(sun_azimuth), .sun_elevation(sun_elevation),
    .time_valid(time_valid), .gps_fix(gps_fix), .gps_site(gps_site),
    .disable_wr(disable_wr), .disable_val(disable_val), .cyclic_due(cyclic_due),
    .height_obj(height_obj), .height_send(height_send), .site(site));
  actuator_model #(.N(NF)) act (.pclk(pclk), .presetn(presetn), .height_obj(height_obj),
    .height_send(height_send), .last(last), .n_sent(n_sent));

  always #2.5 pclk = ~pclk;
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk

  // One random sensor carries the light, the other three stay dark
  task automatic set_lux(input logic [19:0] v);
    logic [3:0][19:0] t;
    t = '0;
    t[$unsigned($random(seed)) % 4] = v;
    bright_lux <= t;
    tick(4);
  endtask : set_lux

  task automatic pulse(input logic [NF-1:0] w, input logic [NF-1:0] v);
    disable_wr <= w;
    disable_val <= v;
    @(posedge pclk);
    disable_wr <= '0;
    tick(3);
  endtask : pulse

  // Stage angles 10/20/30, percentages 80/50/20
  function automatic logic [11:0] exp_obj(input logic signed [7:0] e);
    logic [2:0] s;
    s = {e > 8'sh1e, e > 8'sh14, e > 8'sh0a};
    return {1'b1, s, s[2] ? 8'h14 : s[1] ? 8'h32 : s[0] ? 8'h50 : 8'h64};
  endfunction : exp_obj

  task automatic band(input logic signed [7:0] e);
    sun_elevation <= e;
    tick(4);
    x = exp_obj(e);
    chk(32'(last[0]), 32'({x[11], 3'b000, x[7:0]}));
    chk(32'(last[1][11:8]), 32'(x[11:8]));
  endtask : band

  initial begin
    tick(20);
    presetn <= 1'b1;
    rdchk(CTRL_OFS, 32'h0);
    rdchk(BRIGHT_OFS, 32'h0000030a);
    rdchk(STATUS_OFS, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(32'(err), 32'h1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ra[i], rv[i]);
      rdchk(ra[i], re[i]);
    end
    gps_fix <= 1'b1;
    gps_site <= '{lon: 32'sh0d, lat: 32'sh34, hgt: 16'h0022};
    tick(2);
    chk(32'(site.hgt), 32'h2290);
    chk(site.lon, 32'hffffff4c);
    apb(1'b1, CTRL_OFS, 32'h3);
    tick(1);
    chk(32'(site.hgt), 32'h0022);
    for (int f = 0; f < NF; f++) begin
      apb(1'b1, FAC_BASE + 12'(16 * f + 4), 32'h005a00b4);
      apb(1'b1, FAC_BASE + 12'(16 * f + 8), 32'h001e140a);
      apb(1'b1, FAC_BASE + 12'(16 * f + 12), 32'h00143250);
    end
    apb(1'b1, FAC_BASE, 32'hff);
    apb(1'b1, FAC_BASE + 12'h010, 32'h2e);
    time_valid <= 1'b1;
    set_lux(20'd20000);
    band(8'sh05);
    rdchk(STATUS_OFS, 32'h00030003);
    band(8'sh0a);
    band(8'sh0b);
    // Random bands, boundaries included
    for (int k = 0; k < 12; k++) begin
      band(8'($unsigned($random(seed)) % 4 * 10 + 1 + $unsigned($random(seed)) % 10));
    end
    sent0 = n_sent;
    tick(20);
    chk(32'(n_sent), 32'(sent0));
    set_lux(20'd8000);
    chk(32'(last[0].shade), 32'h1);
    set_lux(20'd6999);
    chk(32'(last), 32'h0);
    set_lux(20'd20000);
    band(8'sh23);
    sun_azimuth <= 9'h0e1;
    tick(4);
    chk(32'(last[0].shade), 32'h1);
    sun_azimuth <= 9'h0e2;
    tick(4);
    chk(32'(last), 32'h0);
    sun_azimuth <= 9'h0b4;
    apb(1'b1, BRIGHT_OFS, 32'h00000103);
    set_lux(20'd1999);
    set_lux(20'd3000);
    chk(32'(last[0]), 32'h0);
    set_lux(20'd3001);
    chk(32'(last[0].shade), 32'h1);
    set_lux(20'd0);
    apb(1'b1, EXT_LUX_OFS, 32'h1f4);
    apb(1'b1, CTRL_OFS, 32'h5);
    set_lux(20'd501);
    band(8'sh05);
    pulse(2'b11, 2'b01);
    chk(32'(last[0]), 32'h0);
    chk(32'(last[1][11:8]), 32'h8);
    sent0 = n_sent;
    sun_elevation <= 8'sh19;
    tick(6);
    chk(32'(n_sent), 32'(sent0));
    pulse(2'b01, 2'b00);
    x = exp_obj(8'sh19);
    chk(32'(last[0]), 32'({x[11], 3'b000, x[7:0]}));
    pulse(2'b10, 2'b10);
    chk(32'(last[1][11:8]), 32'h8);
    cyclic_due <= 2'b10;
    @(posedge pclk);
    cyclic_due <= '0;
    tick(3);
    chk(32'(last[1][11:8]), 32'hb);
    pulse(2'b10, 2'b00);
    time_valid <= 1'b0;
    tick(4);
    chk(32'(last), 32'h0);
    time_valid <= 1'b1;
    tick(4);
    apb(1'b1, CTRL_OFS, 32'h0);
    tick(4);
    chk(32'(height_obj), 32'h0);
    // Second reset while a facade is disabled
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(32'(rd[15:8]), 32'h0);
    final_report();
  end
endmodule : tb
`default_nettype wire
